// file: verilog/usi_two_wire_shift_unit.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "usi_regs.svh"

module usi_two_wire_shift_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire usi_pkg::usi_apb_req_t apb_req,
  output usi_pkg::usi_apb_rsp_t apb_rsp,
  input wire usi_pkg::usi_pin_in_t pin_in,
  output usi_pkg::usi_pin_out_t pin_out,
  input wire logic timer_match,
  input wire logic global_irq_enable,
  output logic start_irq,
  output logic ovf_irq
);

  usi_pkg::usi_state_t st;
  usi_pkg::usi_state_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  // Byte address of a register index
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {idx[5:0], 2'h0});
  endfunction

  // Three-stage sampler: level moves once stages two and three agree
  function automatic logic settle(input logic [2:0] sync, input logic lvl);
    settle = (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction

  // Two-wire selected (both upper modes)
  function automatic logic is_two_wire(input logic [7:0] ctrl);
    is_two_wire = ctrl[`USI_CTL_WM_HI];
  endfunction

  // ****************************************
  // Combinational next state
  // ****************************************
  always_comb begin
    logic [1:0] wm;
    logic [1:0] cs;
    logic two_wire;
    logic new_scl;
    logic new_sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    logic acc;
    logic wr;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic strobe_clk;
    logic strobe_tgl;
    logic shift_tick;
    logic count_tick;
    logic latch_open;
    logic [7:0] rd;
    logic [3:0] cnt_plus;
    next_st = st;
    wm = st.ctrl[`USI_CTL_WM_HI:`USI_CTL_WM_LO];
    cs = st.ctrl[`USI_CTL_CS_HI:`USI_CTL_CS_LO];
    two_wire = is_two_wire(st.ctrl);
    rd = `USI_RST_BYTE;

    // Pin sampling, no extra glitch filter beyond sampler
    next_st.scl_sync = {st.scl_sync[1:0], pin_in.scl};
    next_st.sda_sync = {st.sda_sync[1:0], pin_in.sda};
    new_scl = settle(st.scl_sync, st.scl_lvl);
    new_sda = settle(st.sda_sync, st.sda_lvl);
    next_st.scl_lvl = new_scl;
    next_st.sda_lvl = new_sda;
    scl_rise = new_scl & ~st.scl_lvl;
    scl_fall = ~new_scl & st.scl_lvl;
    sda_rise = new_sda & ~st.sda_lvl;
    sda_fall = ~new_sda & st.sda_lvl;

    // APB decode; write lands on the access edge
    acc = apb_req.psel & apb_req.penable & st.rsp.pready;
    wr = acc & apb_req.pwrite;
    wr_ctrl = wr & reg_hit(apb_req.paddr, `USI_IDX_CONTROL);
    wr_stat = wr & reg_hit(apb_req.paddr, `USI_IDX_STATUS);
    wr_data = wr & reg_hit(apb_req.paddr, `USI_IDX_DATA);
    strobe_clk = wr_ctrl & apb_req.pwdata[`USI_CTL_CLKSEL];
    strobe_tgl = wr_ctrl & apb_req.pwdata[`USI_CTL_TOGGLE];

    // Clock source selection
    shift_tick = 1'b0;
    count_tick = 1'b0;
    case (cs)
      `USI_CS_SOFT: begin
        shift_tick = strobe_clk;
        count_tick = strobe_clk;
      end
      `USI_CS_TIMER: begin
        shift_tick = timer_match;
        count_tick = timer_match;
      end
      default: begin
        if (st.ctrl[`USI_CTL_CLKSEL]) begin
          // Toggle strobe stands in for the pin edge
          shift_tick = strobe_tgl;
          count_tick = strobe_tgl;
        end else begin
          // Sample on rising edge, or falling when cs low bit set
          shift_tick = (cs == `USI_CS_EXT_RISE) ? scl_rise : scl_fall;
          count_tick = scl_rise | scl_fall; // Both edges counted
        end
      end
    endcase

    // Control register, strobe bits not stored
    if (wr_ctrl) begin
      next_st.ctrl = {apb_req.pwdata[7:2], 2'h0};
    end
    if (wr & reg_hit(apb_req.paddr, `USI_IDX_PORT)) begin
      next_st.port = apb_req.pwdata[3:0];
    end
    // Toggle strobe flips the clock port value
    if (strobe_tgl) begin
      next_st.port[`USI_PORT_SCL_VAL] = ~st.port[`USI_PORT_SCL_VAL];
    end

    // Shift register; a CPU write wins over the shift
    if (wr_data) begin
      next_st.shift = apb_req.pwdata[7:0];
    end else if (shift_tick) begin
      next_st.shift = {st.shift[6:0], new_sda}; // Left shift
    end

    // Edge counter and overflow
    cnt_plus = st.cnt + 4'h1;
    if (wr_stat) begin
      next_st.cnt = apb_req.pwdata[3:0];
    end else if (count_tick) begin
      next_st.cnt = cnt_plus;
    end
    // Wrap from top sets flag, preload of max works too
    if (count_tick && !wr_stat && st.cnt == `USI_CNT_MAX) begin
      next_st.ovf_flag = 1'b1;
      next_st.rbuf = next_st.shift; // Completed byte to buffer
      if (two_wire && wm[0]) begin
        next_st.ovf_hold = 1'b1; // Hold clock after eight bits
      end
    end else if (wr_stat && apb_req.pwdata[`USI_ST_OVF]) begin
      next_st.ovf_flag = 1'b0;
      next_st.ovf_hold = 1'b0; // Clearing releases the hold
    end

    // Start detector: data delayed before clock is looked at
    // Runs on sampled pins, so no wake while pclk is stopped
    case (st.sd_state)
      usi_pkg::USI_SD_IDLE: begin
        if (two_wire && sda_fall && new_scl) begin
          next_st.sd_state = usi_pkg::USI_SD_DELAY;
          next_st.sd_cnt = 4'(`USI_SDA_DLY_CYC);
        end
      end
      usi_pkg::USI_SD_DELAY: begin
        if (st.sd_cnt != 4'h0) begin
          next_st.sd_cnt = st.sd_cnt - 4'h1;
        end else if (new_scl && !new_sda) begin
          next_st.sd_state = usi_pkg::USI_SD_SEEN; // Start recognised
        end else begin
          next_st.sd_state = usi_pkg::USI_SD_IDLE;
        end
      end
      usi_pkg::USI_SD_SEEN: begin
        if (scl_fall) begin
          next_st.start_hold = 1'b1; // Clock held after master fall
          next_st.sd_state = usi_pkg::USI_SD_IDLE;
        end else if (sda_rise) begin
          next_st.sd_state = usi_pkg::USI_SD_IDLE;
        end
      end
      default: begin
        next_st.sd_state = usi_pkg::USI_SD_IDLE;
      end
    endcase
    if (!two_wire) begin
      next_st.sd_state = usi_pkg::USI_SD_IDLE;
      next_st.start_hold = 1'b0;
      next_st.ovf_hold = 1'b0;
    end

    // Start flag: write one clears, a new set wins
    if (wr_stat && apb_req.pwdata[`USI_ST_START]) begin
      next_st.start_flag = 1'b0;
      next_st.start_hold = 1'b0; // Release start hold
    end
    if (st.sd_state == usi_pkg::USI_SD_DELAY && st.sd_cnt == 4'h0 && new_scl && !new_sda) begin
      next_st.start_flag = 1'b1;
    end
    // Outside two-wire, any external clock edge flags
    if (!two_wire && cs[1] && !st.ctrl[`USI_CTL_CLKSEL] && (scl_rise || scl_fall)) begin
      next_st.start_flag = 1'b1;
    end

    // Stop: data rises while clock high
    if (wr_stat && apb_req.pwdata[`USI_ST_STOP]) begin
      next_st.stop_flag = 1'b0;
    end
    if (two_wire && sda_rise && new_scl) begin
      next_st.stop_flag = 1'b1;
    end

    // Output latch: open in first half of external clock
    if (cs[1]) begin
      latch_open = cs[0] ? new_scl : ~new_scl;
    end else begin
      latch_open = 1'b1;
    end
    if (latch_open) begin
      next_st.out_latch = next_st.shift[7]; // Follows bit seven
    end

    // Open drain pins; data enabled only with direction set, clock also by holds
    next_st.pins.scl_o = 1'b0;
    next_st.pins.sda_o = 1'b0;
    next_st.pins.sda_oe = two_wire && st.port[`USI_PORT_SDA_DIR] &&
      !(next_st.out_latch && st.port[`USI_PORT_SDA_VAL]);
    next_st.pins.scl_oe = two_wire && ((st.port[`USI_PORT_SCL_DIR] &&
      !next_st.port[`USI_PORT_SCL_VAL]) || next_st.start_hold || next_st.ovf_hold);

    // Interrupt requests, level while flag and enables set
    next_st.start_irq = next_st.start_flag && next_st.ctrl[`USI_CTL_START_IE] && global_irq_enable;
    next_st.ovf_irq = next_st.ovf_flag && next_st.ctrl[`USI_CTL_OVF_IE] && global_irq_enable;

    // APB answer: ready in the first access cycle
    next_st.rsp.pready = apb_req.psel & ~apb_req.penable;
    next_st.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      if (reg_hit(apb_req.paddr, `USI_IDX_CONTROL)) begin
        rd = st.ctrl;
      end else if (reg_hit(apb_req.paddr, `USI_IDX_STATUS)) begin
        // Collision reads sampled data level against bit seven
        rd = {st.start_flag, st.ovf_flag, st.stop_flag,
          two_wire & (st.shift[7] != st.sda_lvl), st.cnt};
      end else if (reg_hit(apb_req.paddr, `USI_IDX_DATA)) begin
        rd = st.shift;
      end else if (reg_hit(apb_req.paddr, `USI_IDX_BUFFER)) begin
        rd = st.rbuf;
      end else if (reg_hit(apb_req.paddr, `USI_IDX_PORT)) begin
        rd = {4'h0, st.port};
      end else begin
        next_st.rsp.pslverr = 1'b1; // Unmapped address
      end
      next_st.rsp.prdata = {24'h000000, rd};
    end
  end

  // ****************************************
  // State register; clock enable freezes all
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.scl_sync <= 3'h7;
      st.sda_sync <= 3'h7;
      st.scl_lvl <= 1'b1;
      st.sda_lvl <= 1'b1;
      st.sd_state <= usi_pkg::USI_SD_IDLE;
      st.port <= `USI_RST_PORT;
    end else if (pce) begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign apb_rsp = st.rsp;
  assign pin_out = st.pins;
  assign start_irq = st.start_irq;
  assign ovf_irq = st.ovf_irq;

endmodule // usi_two_wire_shift_unit

// file: verilog/usi_regs.svh
`ifndef USI_REGS_SVH
`define USI_REGS_SVH
// Summary of operation
// - Bus protocol; no slew limit, no filter
// - Data falls, clock high: set start flag
// - Data pin follows shift bit seven
// - Start hold on clock fall till clear
// - Receive samples data on rising clock, falling when cs low bit set
// - Overflow after eight bits holds clock low, upper two-wire mode only
// - Detector two-wire only, data delayed first
// - Start detector runs only while pclk runs
// - External clock counts both edges
// - Preload fifteen: next edge overflows
// - Shift left on selected clock source
// - CPU write beats simultaneous shift
// - Mode zero: inputs work, outputs off
// - Output latch open first half clock
// - Data pin driven only when direction set
// - Transfer end copies shift to buffer
// - Non two-wire external: edges set start
// - Start request when flag, enables set
// - Start flag clears on write one
// - Wrap sets overflow; clear releases hold
// - Stop flag in two-wire, write-one clear
// - Collision when bit seven differs pin

// ****************************************
// Register indices, byte address is index times four
// ****************************************
`define USI_IDX_CONTROL 8'h0D
`define USI_IDX_STATUS 8'h0E
`define USI_IDX_DATA 8'h0F
`define USI_IDX_BUFFER 8'h10
`define USI_IDX_PORT 8'h11

// ****************************************
// Field positions
// ****************************************
`define USI_CTL_START_IE 7
`define USI_CTL_OVF_IE 6
`define USI_CTL_WM_HI 5
`define USI_CTL_WM_LO 4
`define USI_CTL_CS_HI 3
`define USI_CTL_CS_LO 2
`define USI_CTL_CLKSEL 1
`define USI_CTL_TOGGLE 0
`define USI_ST_START 7
`define USI_ST_OVF 6
`define USI_ST_STOP 5
`define USI_ST_COLL 4
`define USI_PORT_SDA_DIR 0
`define USI_PORT_SCL_DIR 1
`define USI_PORT_SDA_VAL 2
`define USI_PORT_SCL_VAL 3

// ****************************************
// Encodings and reset values
// ****************************************
`define USI_WM_OFF 2'h0
`define USI_WM_THREE 2'h1
`define USI_CS_SOFT 2'h0
`define USI_CS_TIMER 2'h1
`define USI_CS_EXT_RISE 2'h2
`define USI_CNT_MAX 4'hF
`define USI_RST_BYTE 8'h00
`define USI_RST_PORT 4'hC

// ****************************************
// Timing
// ****************************************
`define USI_SDA_DELAY_NS 50
`define USI_CLK_PERIOD_PS 8000
`define USI_SDA_DLY_CYC (((`USI_SDA_DELAY_NS) * 1000 + `USI_CLK_PERIOD_PS - 1) / `USI_CLK_PERIOD_PS)
`endif

// file: verilog/usi_pkg.sv
package usi_pkg;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } usi_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } usi_apb_rsp_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } usi_pin_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } usi_pin_out_t;

  // Start detector states
  typedef enum logic [2:0] {
    USI_SD_IDLE = 3'h1,
    USI_SD_DELAY = 3'h2,
    USI_SD_SEEN = 3'h4
  } usi_sd_state_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_lvl;
    logic sda_lvl;
    usi_sd_state_t sd_state;
    logic [3:0] sd_cnt;
    logic start_hold;
    logic ovf_hold;
    logic [7:0] ctrl;
    logic [3:0] port;
    logic start_flag;
    logic ovf_flag;
    logic stop_flag;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] rbuf;
    logic out_latch;
    usi_apb_rsp_t rsp;
    usi_pin_out_t pins;
    logic start_irq;
    logic ovf_irq;
  } usi_state_t;
endpackage

// file: verif/usi_two_wire_shift_unit_chk.sv
`timescale 1ns/1ps
module usi_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire usi_pkg::usi_apb_req_t apb_req,
  input wire usi_pkg::usi_apb_rsp_t apb_rsp,
  input wire usi_pkg::usi_pin_in_t pin_in,
  input wire usi_pkg::usi_pin_out_t pin_out,
  input wire logic timer_match,
  input wire logic global_irq_enable,
  input wire logic start_irq,
  input wire logic ovf_irq
);
  // ****************
  // Shadow of mode and pin setup
  // ****************
  logic wm_hi;
  logic sda_dir;
  logic scl_val;
  logic lands;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign lands = apb_req.psel && apb_req.penable && apb_rsp.pready && pce && apb_req.pwrite;
  // Toggle strobe flips clock value, so track it too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wm_hi <= 1'b0;
      sda_dir <= 1'b0;
      scl_val <= 1'b1;
    end else if (lands && apb_req.paddr == 8'h34) begin
      wm_hi <= apb_req.pwdata[5];
      scl_val <= scl_val ^ apb_req.pwdata[0];
    end else if (lands && apb_req.paddr == 8'h44) begin
      sda_dir <= apb_req.pwdata[0];
      scl_val <= apb_req.pwdata[3];
    end
  end
  // ****************
  // Properties
  // ****************
  pready_answer_a: assert property (apb_req.psel && !apb_req.penable && pce |=> apb_rsp.pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (apb_rsp.pready && pce |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  slverr_map_a: assert property (apb_rsp.pready &&
    !(apb_req.paddr inside {8'h34, 8'h38, 8'h3C, 8'h40, 8'h44}) |->
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  irq_gate_a: assert property (!global_irq_enable && pce |=> !start_irq && !ovf_irq)
    else $error("request without global enable");
  out_off_a: assert property (!wm_hi && !$past(wm_hi) |-> !pin_out.scl_oe && !pin_out.sda_oe)
    else $error("output driven outside two-wire");
  dir_gate_a: assert property (!sda_dir && !$past(sda_dir) |-> !pin_out.sda_oe)
    else $error("data driven with input direction");
  hold_cause_a: assert property ($rose(pin_out.scl_oe) && scl_val && $past(scl_val) |->
    !$past(pin_in.scl, 2))
    else $error("clock hold without clock fall");
  pull_only_a: assert property (!pin_out.sda_o && !pin_out.scl_o)
    else $error("pin driven high");
endmodule // usi_chk

bind usi_two_wire_shift_unit usi_chk u_chk (.pclk(pclk), .presetn(presetn), .pce(pce),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out),
  .timer_match(timer_match), .global_irq_enable(global_irq_enable),
  .start_irq(start_irq), .ovf_irq(ovf_irq));

// file: verif/usi_tw_master.sv
`timescale 1ns/1ps
module usi_tw_master (
  input wire logic pclk,
  input wire usi_pkg::usi_pin_out_t pin_out,
  output usi_pkg::usi_pin_in_t pin_in
);
  // ****************
  // Far-side bus master
  // ****************
  logic m_scl_low;
  logic m_sda_low;
  // Pull-ups: a line is low while any side pulls
  assign pin_in.scl = !(m_scl_low || pin_out.scl_oe);
  assign pin_in.sda = !(m_sda_low || pin_out.sda_oe);
  initial begin
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
  end
  // Five cycles a level, an 80 ns bit, far below half rate
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Release clock, then wait while the slave stretches it
  // Release clock, then wait while the slave stretches it; bench watchdog ends a hang
  task automatic rise();
    m_scl_low <= 1'b0;
    do begin
      tick(1);
    end while (pin_in.scl !== 1'b1);
    tick(4);
  endtask
  // Low phase finishes in put_bit or in the caller's own wait
  task automatic fall();
    m_scl_low <= 1'b1;
    tick(3);
  endtask
  task automatic start();
    m_sda_low <= 1'b1;
    tick(15);
    fall();
    tick(5);
  endtask
  task automatic put_bit(input logic b);
    m_sda_low <= !b;
    tick(2);
    rise();
    fall();
  endtask
  task automatic stop();
    m_sda_low <= 1'b1;
    tick(2);
    rise();
    m_sda_low <= 1'b0;
    tick(8);
  endtask
endmodule // usi_tw_master

// file: verif/usi_two_wire_shift_unit_bench.sv
`timescale 1ns/1ps
module usi_two_wire_shift_unit_bench;
  // ****************
  // Bench
  // ****************
  localparam logic [7:0] A_CTL = 8'h34;
  localparam logic [7:0] A_ST = 8'h38;
  localparam logic [7:0] A_DAT = 8'h3C;
  localparam logic [7:0] A_BUF = 8'h40;
  localparam logic [7:0] ADR = 8'hA5;
  logic pclk;
  logic presetn;
  logic pce;
  logic timer_match;
  logic global_irq_enable;
  logic start_irq;
  logic ovf_irq;
  logic scl_oe_q;
  logic sda_q;
  logic sirq_q;
  logic oirq_q;
  logic [7:0] rdv;
  logic err;
  int i;
  int miscompares;
  int n_compared;
  usi_pkg::usi_apb_req_t req;
  usi_pkg::usi_apb_rsp_t rsp;
  usi_pkg::usi_pin_in_t pin_in;
  usi_pkg::usi_pin_out_t pin_out;
  usi_two_wire_shift_unit u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .apb_req(req),
    .apb_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .timer_match(timer_match),
    .global_irq_enable(global_irq_enable), .start_irq(start_irq), .ovf_irq(ovf_irq));
  usi_tw_master u_m (.pclk(pclk), .pin_out(pin_out), .pin_in(pin_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Captured mid-cycle so checks never race the edge
  always @(negedge pclk) begin
    scl_oe_q <= pin_out.scl_oe;
    sda_q <= pin_in.sda;
    sirq_q <= start_irq;
    oirq_q <= ovf_irq;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One transfer; tm pulses the timer source as the transfer lands
  task automatic apb(input logic we, input logic [7:0] a, input logic [7:0] wd, input logic tm);
    req <= '{1'b1, 1'b0, we, a, {24'h0, wd}};
    @(posedge pclk);
    req.penable <= 1'b1;
    timer_match <= tm;
    // Answer taken at the edge where pready is seen high; watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rdv = rsp.prdata[7:0];
    err = rsp.pslverr;
    req <= '0;
    timer_match <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    apb(1'b0, a, 8'h00, 1'b0);
    check(rdv & m, exp);
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    pce = 1'b1;
    timer_match = 1'b0;
    global_irq_enable = 1'b0;
    req = '0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reg_rd(A_ST, 8'hFF, 8'h00);
    reg_rd(A_CTL, 8'hFF, 8'h00);
    reg_rd(8'h44, 8'h0F, 8'h0C);
    reg_rd(8'h48, 8'hFF, 8'h00);
    check({7'h0, err}, 8'h01);
    $display("test reset done");
    // Preload max, one software strobe overflows
    reg_wr(A_DAT, 8'h81);
    reg_wr(A_CTL, 8'h40);
    reg_wr(A_ST, 8'h0F);
    reg_wr(A_CTL, 8'h42);
    reg_rd(A_ST, 8'hEF, 8'h40);
    reg_rd(A_DAT, 8'hFF, 8'h03);
    check({7'h0, oirq_q}, 8'h00);
    global_irq_enable <= 1'b1;
    reg_wr(A_ST, 8'h00);
    check({7'h0, oirq_q}, 8'h01);
    reg_rd(A_ST, 8'hC0, 8'h40);
    reg_wr(A_ST, 8'h40);
    reg_rd(A_ST, 8'hC0, 8'h00);
    $display("test strobe done");
    // Timer source, then a write meeting a shift
    reg_wr(A_CTL, 8'h04);
    reg_wr(A_DAT, 8'h81);
    apb(1'b0, A_ST, 8'h00, 1'b1);
    reg_rd(A_DAT, 8'hFF, 8'h03);
    reg_rd(A_ST, 8'h0F, 8'h01);
    apb(1'b1, A_DAT, 8'h55, 1'b1);
    reg_rd(A_DAT, 8'hFF, 8'h55);
    $display("test timer done");
    // Outputs off, external clock still counts and shifts
    reg_wr(A_CTL, 8'h08);
    reg_wr(A_ST, 8'hF0);
    reg_wr(A_DAT, 8'h00);
    u_m.fall();
    u_m.rise();
    reg_rd(A_ST, 8'h8F, 8'h82);
    reg_rd(A_DAT, 8'hFF, 8'h01);
    $display("test mode off done");
    // Two-wire slave: start, address byte, acknowledge, stop
    reg_wr(8'h44, 8'h0F);
    // Internal source keeps the latch open, so the high bit reaches it first
    reg_wr(A_CTL, 8'h00);
    reg_wr(A_DAT, 8'hFF);
    reg_wr(A_CTL, 8'hB8);
    reg_wr(A_ST, 8'hF0);
    u_m.start();
    check({7'h0, sirq_q}, 8'h01);
    check({7'h0, scl_oe_q}, 8'h01);
    reg_rd(A_ST, 8'h90, 8'h90);
    reg_wr(A_ST, 8'h80);
    check({7'h0, scl_oe_q}, 8'h00);
    for (i = 7; i >= 0; i--) begin
      u_m.put_bit(ADR[i]);
    end
    u_m.tick(2);
    reg_rd(A_ST, 8'hCF, 8'h40);
    check({7'h0, scl_oe_q}, 8'h01);
    reg_rd(A_BUF, 8'hFF, ADR);
    reg_rd(A_DAT, 8'hFF, ADR);
    reg_wr(A_DAT, 8'h00);
    reg_wr(A_ST, 8'h4E);
    u_m.rise();
    check({7'h0, sda_q}, 8'h00);
    u_m.fall();
    u_m.tick(2);
    reg_rd(A_ST, 8'h4F, 8'h40);
    reg_wr(A_DAT, 8'hFF);
    reg_wr(A_ST, 8'h40);
    u_m.stop();
    reg_rd(A_ST, 8'hE0, 8'h20);
    reg_wr(A_ST, 8'h20);
    reg_rd(A_ST, 8'h20, 8'h00);
    // After the stop only a fresh start flags again
    check({7'h0, sirq_q}, 8'h00);
    u_m.start();
    check({7'h0, sirq_q}, 8'h01);
    reg_wr(A_ST, 8'h80);
    check({7'h0, scl_oe_q}, 8'h00);
    $display("test two-wire done");
    final_report();
  end
endmodule // usi_two_wire_shift_unit_bench
